// >>> src/quadrature_timer_block.sv
// timer block: 16-bit core up/down counter with encoder interface and two auxiliary counters
// assumes one timer clock; control bits and counter writes arrive as plain ports
//
// Overview of operation
// RQ1: mode 110 or 111 selects encoder operation
// RQ2: step once per selected phase edge
// RQ3: edge select picks phase A, B, both, none
// RQ4: direction from edge sense and other phase
// RQ5: rotation mode requests interrupt on direction change
// RQ6: edge mode requests interrupt on every step
// RQ7: encoder interrupt only while its enable set
// RQ8: direction, changed and edge status bits kept
// RQ9: software sets external direction enable for encoder
// RQ10: phase levels held four clocks minimum
// RQ11: aux A adds encoder mode, aux B not
// RQ12: remote run bit follows core run bit
// RQ13: aux timer modes match core, no latch
// RQ14: aux counter edge select on own input
// RQ15: codes 101-111 count toggle-latch transitions
// RQ16: software latch writes never clock aux counters
// RQ17: aux B counter mode same as aux A
// RQ18: shared functions share field codes and behaviour
// RQ19: each overflow or underflow inverts toggle latch; in the code a latch write in the same cycle wins
// RQ20: core run bit starts and stops core
// RQ21: all three counters are sixteen bits
// RQ22: external inputs synchronised, edges from samples
// RQ23: software counter write beats hardware count
`timescale 1ns/1ns
module quadrature_timer_block (
  input  wire logic                                i_clk,
  input  wire logic                                i_sys_rst,
  // encoder phases and external count lines
  input  wire logic                                i_core_count_input,
  input  wire logic                                i_core_direction_input,
  input  wire logic                                i_aux_a_count_input,
  input  wire logic                                i_aux_a_direction_input,
  input  wire logic                                i_aux_b_count_input,
  input  wire logic                                i_fast_prescale_bit,
  // core control word fields
  input  wire logic [2:0]                          i_core_mode_field,
  input  wire logic [2:0]                          i_core_edge_select,
  input  wire logic                                i_core_run_bit,
  input  wire logic                                i_core_dir_sw,
  input  wire logic                                i_external_direction_enable,
  input  wire logic                                i_encoder_irq_enable,
  input  wire logic                                i_clr_direction_changed,
  input  wire logic                                i_clr_count_edge,
  input  wire logic                                i_otl_wr,
  input  wire logic                                i_otl_wdata,
  input  wire logic                                i_core_wr,
  input  wire logic [quad_timer_pkg::CNT_W-1:0]    i_core_wdata,
  // auxiliary A control word fields
  input  wire logic [2:0]                          i_aux_a_mode,
  input  wire logic [2:0]                          i_aux_a_edge_select,
  input  wire logic                                i_aux_a_run_bit,
  input  wire logic                                i_aux_a_remote_run,
  input  wire logic                                i_aux_a_dir_sw,
  input  wire logic                                i_aux_a_ext_dir_enable,
  input  wire logic                                i_aux_a_wr,
  input  wire logic [quad_timer_pkg::CNT_W-1:0]    i_aux_a_wdata,
  // auxiliary B control word fields
  input  wire logic [2:0]                          i_aux_b_mode,
  input  wire logic [2:0]                          i_aux_b_edge_select,
  input  wire logic                                i_aux_b_run_bit,
  input  wire logic                                i_aux_b_remote_run,
  input  wire logic                                i_aux_b_dir_sw,
  input  wire logic                                i_aux_b_wr,
  input  wire logic [quad_timer_pkg::CNT_W-1:0]    i_aux_b_wdata,
  // counters and status
  output logic      [quad_timer_pkg::CNT_W-1:0]    o_core_count,
  output logic                                     o_core_overflow_toggle_latch,
  output logic                                     o_rotation_direction_flag,
  output logic                                     o_direction_changed_flag,
  output logic                                     o_count_edge_flag,
  output logic                                     o_encoder_irq,
  output logic      [quad_timer_pkg::CNT_W-1:0]    o_aux_a_count,
  output logic      [quad_timer_pkg::CNT_W-1:0]    o_aux_b_count
);

  typedef struct packed {
    logic [quad_timer_pkg::IN_W-1:0]  sync1;
    logic [quad_timer_pkg::IN_W-1:0]  sync2;
    logic [quad_timer_pkg::IN_W-1:0]  prev;
    logic [quad_timer_pkg::PRE_W-1:0] pre;
    logic [quad_timer_pkg::CNT_W-1:0] cnt;
    logic                             otl;
    logic                             otl_rise;
    logic                             otl_fall;
    logic                             dir_flag;
    logic                             chdir_flag;
    logic                             edge_flag;
    logic                             irq;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{
    sync1:      '0,
    sync2:      '0,
    prev:       '0,
    pre:        '0,
    cnt:        quad_timer_pkg::CNT_RESET,
    otl:        1'b0,
    otl_rise:   1'b0,
    otl_fall:   1'b0,
    dir_flag:   1'b0,
    chdir_flag: 1'b0,
    edge_flag:  1'b0,
    irq:        1'b0
  };

  core_state_t                        s_q;
  core_state_t                        s_d;
  logic [quad_timer_pkg::IN_W-1:0]    in_vec;
  logic [quad_timer_pkg::IN_W-1:0]    lvl;
  logic [quad_timer_pkg::IN_W-1:0]    rise;
  logic [quad_timer_pkg::IN_W-1:0]    fall;
  logic                               tick;
  logic                               enc_mode;
  logic [1:0]                         enc;
  logic                               step;
  logic                               down;
  logic                               ovf;
  logic                               dir_change;

  always_comb
  begin
    in_vec = '0;
    in_vec[quad_timer_pkg::LANE_CORE_CNT] = i_core_count_input;
    in_vec[quad_timer_pkg::LANE_CORE_DIR] = i_core_direction_input;
    in_vec[quad_timer_pkg::LANE_AUXA_CNT] = i_aux_a_count_input;
    in_vec[quad_timer_pkg::LANE_AUXB_CNT] = i_aux_b_count_input;
    in_vec[quad_timer_pkg::LANE_AUXA_DIR] = i_aux_a_direction_input;
  end

  // edges only ever come from the second stage against its previous sample
  assign lvl  = s_q.sync2;
  assign rise = s_q.sync2 & ~s_q.prev; // RQ22
  assign fall = ~s_q.sync2 & s_q.prev; // RQ22

  always_comb
  begin
    s_d        = s_q;
    s_d.sync1  = in_vec; // RQ22
    s_d.sync2  = s_q.sync1;
    s_d.prev   = s_q.sync2;
    s_d.pre    = s_q.pre + 1'b1;
    s_d.irq    = 1'b0;
    s_d.otl_rise = 1'b0;
    s_d.otl_fall = 1'b0;

    tick     = quad_timer_pkg::pre_tick(s_q.pre, i_core_edge_select, i_fast_prescale_bit);
    enc_mode = (i_core_mode_field == quad_timer_pkg::MODE_ENC_ROT) ||
               (i_core_mode_field == quad_timer_pkg::MODE_ENC_EDGE); // RQ1
    // phase A is the count line, phase B the direction line
    enc      = quad_timer_pkg::enc_step(i_core_edge_select,
                                        lvl[quad_timer_pkg::LANE_CORE_CNT],
                                        lvl[quad_timer_pkg::LANE_CORE_DIR],
                                        rise[quad_timer_pkg::LANE_CORE_CNT] | fall[quad_timer_pkg::LANE_CORE_CNT],
                                        rise[quad_timer_pkg::LANE_CORE_DIR] | fall[quad_timer_pkg::LANE_CORE_DIR]); // RQ3
    down     = i_core_dir_sw ^ (i_external_direction_enable & lvl[quad_timer_pkg::LANE_CORE_DIR]);

    case (i_core_mode_field)
      quad_timer_pkg::MODE_TIMER:
        step = i_core_run_bit & tick; // RQ20
      quad_timer_pkg::MODE_GATE_LOW:
        step = i_core_run_bit & tick & ~lvl[quad_timer_pkg::LANE_CORE_CNT];
      quad_timer_pkg::MODE_GATE_HIGH:
        step = i_core_run_bit & tick & lvl[quad_timer_pkg::LANE_CORE_CNT];
      quad_timer_pkg::MODE_COUNTER:
        // code 1xx of the edge field is reserved and counts nothing
        step = i_core_run_bit & ~i_core_edge_select[2] &
               quad_timer_pkg::sel_edge(i_core_edge_select[1:0],
                                        rise[quad_timer_pkg::LANE_CORE_CNT],
                                        fall[quad_timer_pkg::LANE_CORE_CNT]);
      quad_timer_pkg::MODE_ENC_ROT, quad_timer_pkg::MODE_ENC_EDGE:
      begin
        step = i_core_run_bit & enc[1]; // RQ2
        down = enc[0]; // RQ4
      end
      default:
        step = 1'b0;
    endcase

    ovf = 1'b0;
    if (i_core_wr)
      s_d.cnt = i_core_wdata; // RQ23
    else if (step)
    begin
      if (down)
      begin
        ovf     = (s_q.cnt == quad_timer_pkg::CNT_MIN);
        s_d.cnt = s_q.cnt - 1'b1; // RQ21
      end
      else
      begin
        ovf     = (s_q.cnt == quad_timer_pkg::CNT_MAX);
        s_d.cnt = s_q.cnt + 1'b1; // RQ21
      end
    end

    // a software write to the latch wins and never produces a count pulse
    if (i_otl_wr)
      s_d.otl = i_otl_wdata; // RQ16
    else if (ovf)
    begin
      s_d.otl      = ~s_q.otl; // RQ19
      s_d.otl_rise = ~s_q.otl; // RQ15
      s_d.otl_fall = s_q.otl; // RQ15
    end

    dir_change = 1'b0;
    if (i_clr_direction_changed)
      s_d.chdir_flag = 1'b0;
    if (i_clr_count_edge)
      s_d.edge_flag = 1'b0;
    // a new event in the clearing cycle overrides the clear
    if (enc_mode && step)
    begin
      dir_change   = (down != s_q.dir_flag);
      s_d.dir_flag = down; // RQ8
      s_d.edge_flag = 1'b1; // RQ8
      if (dir_change)
        s_d.chdir_flag = 1'b1; // RQ8
      if (i_encoder_irq_enable) // RQ7
      begin
        if (i_core_mode_field == quad_timer_pkg::MODE_ENC_ROT)
          s_d.irq = dir_change; // RQ5
        else
          s_d.irq = 1'b1; // RQ6
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      s_q <= CORE_RESET;
    else
      s_q <= s_d;
  end

  assign o_core_count                 = s_q.cnt;
  assign o_core_overflow_toggle_latch = s_q.otl;
  assign o_rotation_direction_flag    = s_q.dir_flag;
  assign o_direction_changed_flag     = s_q.chdir_flag;
  assign o_count_edge_flag            = s_q.edge_flag;
  assign o_encoder_irq                = s_q.irq;

  // aux A takes the count line as phase A and its own direction line as phase B
  aux_counter #(
    .ENC_EN (1'b1)
  ) u_aux_a (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_mode       (i_aux_a_mode),
    .i_edge_sel   (i_aux_a_edge_select),
    .i_run_bit    (i_aux_a_run_bit),
    .i_remote_run (i_aux_a_remote_run),
    .i_core_run   (i_core_run_bit),
    .i_dir_sw     (i_aux_a_dir_sw),
    .i_dir_ext_en (i_aux_a_ext_dir_enable),
    .i_fast       (i_fast_prescale_bit),
    .i_pre        (s_q.pre),
    .i_in_lvl     (lvl[quad_timer_pkg::LANE_AUXA_CNT]),
    .i_in_prev    (s_q.prev[quad_timer_pkg::LANE_AUXA_CNT]),
    .i_dir_lvl    (lvl[quad_timer_pkg::LANE_AUXA_DIR]),
    .i_dir_prev   (s_q.prev[quad_timer_pkg::LANE_AUXA_DIR]),
    .i_otl_rise   (s_q.otl_rise),
    .i_otl_fall   (s_q.otl_fall),
    .i_wr         (i_aux_a_wr),
    .i_wdata      (i_aux_a_wdata),
    .o_count      (o_aux_a_count)
  );

  // aux B has no direction line: software direction only, no encoder mode
  aux_counter #(
    .ENC_EN (1'b0)
  ) u_aux_b (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_mode       (i_aux_b_mode),
    .i_edge_sel   (i_aux_b_edge_select),
    .i_run_bit    (i_aux_b_run_bit),
    .i_remote_run (i_aux_b_remote_run),
    .i_core_run   (i_core_run_bit),
    .i_dir_sw     (i_aux_b_dir_sw),
    .i_dir_ext_en (1'b0),
    .i_fast       (i_fast_prescale_bit),
    .i_pre        (s_q.pre),
    .i_in_lvl     (lvl[quad_timer_pkg::LANE_AUXB_CNT]),
    .i_in_prev    (s_q.prev[quad_timer_pkg::LANE_AUXB_CNT]),
    .i_dir_lvl    (1'b0),
    .i_dir_prev   (1'b0),
    .i_otl_rise   (s_q.otl_rise),
    .i_otl_fall   (s_q.otl_fall),
    .i_wr         (i_aux_b_wr),
    .i_wdata      (i_aux_b_wdata),
    .o_count      (o_aux_b_count)
  );

endmodule

// >>> src/quad_timer_pkg.sv
// shared constants, mode codes and decode functions of the quadrature timer block
// assumes one timer clock; all counter inputs arrive as plain levels
package quad_timer_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 10;
  localparam int IN_W  = 5;

  // synchroniser lane positions
  localparam int LANE_CORE_CNT = 0;
  localparam int LANE_CORE_DIR = 1;
  localparam int LANE_AUXA_CNT = 2;
  localparam int LANE_AUXB_CNT = 3;
  localparam int LANE_AUXA_DIR = 4;

  // prescale: divide by 8 << sel, or by 4 << sel with the fast bit
  localparam logic [3:0] PRE_SHIFT_SLOW = 4'h3;
  localparam logic [3:0] PRE_SHIFT_FAST = 4'h2;

  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_MIN   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  // same field code in every control word of the three counters
  typedef enum logic [2:0] {
    MODE_TIMER     = 3'h0,
    MODE_COUNTER   = 3'h1,
    MODE_GATE_LOW  = 3'h2,
    MODE_GATE_HIGH = 3'h3,
    MODE_RELOAD    = 3'h4,
    MODE_CAPTURE   = 3'h5,
    MODE_ENC_ROT   = 3'h6,
    MODE_ENC_EDGE  = 3'h7
  } mode_t;

  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_RISE = 2'h1;
  localparam logic [1:0] SEL_FALL = 2'h2;
  localparam logic [1:0] SEL_ANY  = 2'h3;

  // one cycle in 2^(shift+sel) of the free prescale counter
  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] sel, input logic fast);
    logic [3:0]       sh;
    logic [PRE_W-1:0] mask;
    sh   = (fast ? PRE_SHIFT_FAST : PRE_SHIFT_SLOW) + {1'b0, sel};
    mask = PRE_W'((11'h001 << sh) - 11'h001);
    return (cnt & mask) == mask;
  endfunction

  // counter-mode edge choice on one line
  function automatic logic sel_edge(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      SEL_RISE: return rise;
      SEL_FALL: return fall;
      SEL_ANY:  return rise | fall;
      default:  return 1'b0;
    endcase
  endfunction

  // encoder step: {valid, down}; a/b are new levels, ea/eb their edges
  function automatic logic [1:0] enc_step(input logic [2:0] sel, input logic a, input logic b,
                                          input logic ea, input logic eb);
    logic use_a;
    logic use_b;
    use_a = ea & (sel == 3'h1 || sel == 3'h3);
    use_b = eb & (sel == 3'h2 || sel == 3'h3);
    // an edge on phase A wins if both phases move together
    if (use_a)
      return {1'b1, ~(a ^ b)};
    else if (use_b)
      return {1'b1, a ^ b};
    else
      return 2'b00;
  endfunction

endpackage

// >>> src/aux_counter.sv
// one 16-bit auxiliary counter: timer, gated timer, counter and optional encoder mode
// assumes synchronised input levels and their previous samples from the parent
`timescale 1ns/1ns
module aux_counter #(
  parameter bit ENC_EN = 1'b1
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic [2:0]                          i_mode,
  input  wire logic [2:0]                          i_edge_sel,
  input  wire logic                                i_run_bit,
  input  wire logic                                i_remote_run,
  input  wire logic                                i_core_run,
  input  wire logic                                i_dir_sw,
  input  wire logic                                i_dir_ext_en,
  input  wire logic                                i_fast,
  input  wire logic [quad_timer_pkg::PRE_W-1:0]    i_pre,
  input  wire logic                                i_in_lvl,
  input  wire logic                                i_in_prev,
  input  wire logic                                i_dir_lvl,
  input  wire logic                                i_dir_prev,
  input  wire logic                                i_otl_rise,
  input  wire logic                                i_otl_fall,
  input  wire logic                                i_wr,
  input  wire logic [quad_timer_pkg::CNT_W-1:0]    i_wdata,
  output logic      [quad_timer_pkg::CNT_W-1:0]    o_count
);

  typedef struct packed {
    logic [quad_timer_pkg::CNT_W-1:0] cnt;
  } aux_state_t;

  aux_state_t s_q;
  aux_state_t s_d;
  logic       run;
  logic       step;
  logic       down;
  logic [1:0] enc;

  always_comb
  begin
    s_d  = s_q;
    run  = i_remote_run ? i_core_run : i_run_bit; // RQ12
    down = i_dir_sw ^ (i_dir_ext_en & i_dir_lvl);
    enc  = quad_timer_pkg::enc_step(i_edge_sel, i_in_lvl, i_dir_lvl,
                                    i_in_lvl ^ i_in_prev, i_dir_lvl ^ i_dir_prev);
    case (i_mode)
      // RQ13 RQ18
      quad_timer_pkg::MODE_TIMER:
        step = run & quad_timer_pkg::pre_tick(i_pre, i_edge_sel, i_fast);
      quad_timer_pkg::MODE_GATE_LOW:
        step = run & ~i_in_lvl & quad_timer_pkg::pre_tick(i_pre, i_edge_sel, i_fast);
      quad_timer_pkg::MODE_GATE_HIGH:
        step = run & i_in_lvl & quad_timer_pkg::pre_tick(i_pre, i_edge_sel, i_fast);
      quad_timer_pkg::MODE_COUNTER:
      begin
        // toggle-latch pulses come only from real overflows
        if (i_edge_sel[2])
          step = run & quad_timer_pkg::sel_edge(i_edge_sel[1:0], i_otl_rise, i_otl_fall); // RQ15 RQ16
        else
          step = run & quad_timer_pkg::sel_edge(i_edge_sel[1:0], i_in_lvl & ~i_in_prev,
                                                ~i_in_lvl & i_in_prev); // RQ14 RQ17
      end
      quad_timer_pkg::MODE_ENC_ROT, quad_timer_pkg::MODE_ENC_EDGE:
      begin
        step = ENC_EN & run & enc[1]; // RQ11
        down = enc[0];
      end
      default:
        step = 1'b0; // RQ11
    endcase
    if (i_wr)
      s_d.cnt = i_wdata; // RQ23
    else if (step)
      s_d.cnt = down ? s_q.cnt - 1'b1 : s_q.cnt + 1'b1; // RQ21
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      s_q <= '{cnt: quad_timer_pkg::CNT_RESET};
    else
      s_q <= s_d;
  end

  assign o_count = s_q.cnt;

endmodule

// >>> test/quadrature_timer_block_props.sv
// port assertions for the quadrature timer block
// assumes control fields stay steady while encoder phases move
`timescale 1ns/1ns
module quadrature_timer_block_props (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_core_count_input,
  input  wire logic [2:0]  i_core_mode_field,
  input  wire logic [2:0]  i_core_edge_select,
  input  wire logic        i_core_run_bit,
  input  wire logic        i_external_direction_enable,
  input  wire logic        i_encoder_irq_enable,
  input  wire logic        i_clr_direction_changed,
  input  wire logic        i_clr_count_edge,
  input  wire logic        i_otl_wr,
  input  wire logic        i_core_wr,
  input  wire logic [15:0] i_core_wdata,
  input  wire logic [15:0] o_core_count,
  input  wire logic        o_core_overflow_toggle_latch,
  input  wire logic        o_rotation_direction_flag,
  input  wire logic        o_direction_changed_flag,
  input  wire logic        o_count_edge_flag,
  input  wire logic        o_encoder_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence a_edge_s;
    $changed(i_core_count_input) && i_core_mode_field == 3'h7 && i_core_edge_select == 3'h3;
  endsequence
  sequence irq_armed_s;
    i_core_run_bit && i_external_direction_enable && i_encoder_irq_enable;
  endsequence
  // sync chain plus interrupt register: three edges of latency
  edge_irq_a: assert property (a_edge_s ##0 irq_armed_s |-> ##[2:4] o_encoder_irq)
    else $error("no interrupt after counted phase edge");
  irq_gate_a: assert property (o_encoder_irq |-> i_encoder_irq_enable)
    else $error("interrupt while disabled");
  irq_mode_a: assert property (o_encoder_irq |-> i_core_mode_field[2:1] == 2'b11)
    else $error("interrupt outside encoder modes");
  rot_irq_a: assert property ($changed(o_rotation_direction_flag) && i_core_mode_field == 3'h6
                              && i_encoder_irq_enable |-> o_encoder_irq)
    else $error("direction change without interrupt");
  dir_chg_a: assert property ($changed(o_rotation_direction_flag) |-> o_direction_changed_flag)
    else $error("direction change not recorded");
  edge_clr_a: assert property ($fell(o_count_edge_flag) |-> $past(i_clr_count_edge))
    else $error("edge flag dropped without clear");
  chg_clr_a: assert property ($fell(o_direction_changed_flag) |-> $past(i_clr_direction_changed))
    else $error("change flag dropped without clear");
  step_one_a: assert property ($changed(o_core_count) && !$past(i_core_wr) |->
                               o_core_count - $past(o_core_count) inside {16'h0001, 16'hffff})
    else $error("core count moved by more than one");
  write_win_a: assert property ($past(i_core_wr) |-> o_core_count == $past(i_core_wdata))
    else $error("core write not taken");
  run_stop_a: assert property (!i_core_run_bit && !$past(i_core_run_bit) && !$past(i_core_wr)
                               |-> $stable(o_core_count))
    else $error("core counted while stopped");
  otl_wrap_a: assert property ($changed(o_core_overflow_toggle_latch) && !$past(i_otl_wr)
                               |-> {$past(o_core_count), o_core_count} inside {32'hffff0000, 32'h0000ffff})
    else $error("toggle latch moved without wrap");
endmodule

// >>> test/quad_encoder_model.sv
// behavioural incremental encoder plus the two auxiliary count lines
// assumes tasks are called at falling clock edges
`timescale 1ns/1ns
module quad_encoder_model (
  input  wire logic i_clk,
  output logic      o_phase_a,
  output logic      o_phase_b,
  output logic      o_aux_a,
  output logic      o_aux_b,
  output logic      o_aux_dir
);
  logic [1:0] pos = 2'h0;
  initial
  begin
    {o_phase_a, o_phase_b, o_aux_a, o_aux_b, o_aux_dir} = 5'h00;
  end
  // twice the minimum hold, so no edge is lost in the synchroniser
  task automatic hold;
    repeat (8) @(negedge i_clk);
  endtask
  // gray order 00,10,11,01 is forward; one phase moves per step
  task automatic step(input logic fwd);
    pos = fwd ? pos + 2'h1 : pos - 2'h1;
    @(negedge i_clk);
    o_phase_a = pos[0] ^ pos[1];
    o_phase_b = pos[1];
    hold();
  endtask
  task automatic toggle_aux;
    @(negedge i_clk);
    {o_aux_a, o_aux_b} = ~{o_aux_a, o_aux_b};
    hold();
  endtask
endmodule

// >>> test/tb_quadrature_timer_block.sv
// self-checking bench for the quadrature timer block
// assumes the encoder model drives every phase and count line
`timescale 1ns/1ns
module tb_quadrature_timer_block;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_fast_prescale_bit = 1'b0, i_core_dir_sw = 1'b1;
  logic        i_core_count_input, i_core_direction_input, i_aux_a_count_input, i_aux_a_direction_input;
  logic        i_aux_b_count_input, i_core_run_bit = 1'b1, i_external_direction_enable = 1'b1;
  logic [2:0]  i_core_mode_field = 3'h7, i_core_edge_select = 3'h3, i_aux_a_mode = 3'h1, i_aux_b_mode = 3'h1;
  logic [2:0]  i_aux_a_edge_select = 3'h0, i_aux_b_edge_select = 3'h0;
  logic        i_encoder_irq_enable = 1'b1, i_clr_direction_changed = 1'b0, i_clr_count_edge = 1'b0;
  logic        i_otl_wr = 1'b0, i_otl_wdata = 1'b0, i_core_wr = 1'b0, i_aux_a_wr = 1'b0, i_aux_b_wr = 1'b0;
  logic        i_aux_a_run_bit = 1'b1, i_aux_a_remote_run = 1'b0, i_aux_a_dir_sw = 1'b0, i_aux_a_ext_dir_enable = 1'b0;
  logic        i_aux_b_run_bit = 1'b0, i_aux_b_remote_run = 1'b1, i_aux_b_dir_sw = 1'b0;
  logic [15:0] i_core_wdata = 16'h0000, i_aux_a_wdata = 16'h0000, i_aux_b_wdata = 16'h0000;
  logic [15:0] o_core_count, o_aux_a_count, o_aux_b_count;
  logic        o_core_overflow_toggle_latch, o_rotation_direction_flag, o_direction_changed_flag;
  logic        o_count_edge_flag, o_encoder_irq;
  int          fails = 0, cmp_count = 0, irqs = 0, base = 0, ea = 0, eb = 0;
  int          sel_gain [3] = '{0, 2, 2};
  int          aux_gain [3] = '{1, 1, 2};

  quadrature_timer_block dut (.*);
  quad_encoder_model enc (.i_clk(i_clk), .o_phase_a(i_core_count_input), .o_phase_b(i_core_direction_input),
                          .o_aux_a(i_aux_a_count_input), .o_aux_b(i_aux_b_count_input),
                          .o_aux_dir(i_aux_a_direction_input));

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_encoder_irq === 1'b1) irqs <= irqs + 1;

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr_all(input logic [15:0] c, input logic [15:0] a, input logic [15:0] b);
    @(negedge i_clk);
    {i_core_wr, i_aux_a_wr, i_aux_b_wr} = 3'h7;
    {i_core_wdata, i_aux_a_wdata, i_aux_b_wdata} = {c, a, b};
    @(negedge i_clk);
    {i_core_wr, i_aux_a_wr, i_aux_b_wr} = 3'h0;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic summarize;
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    repeat (4) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    chk16(o_core_count, 16'h0000);
    repeat (4) enc.step(1'b1);
    chk16(o_core_count, 16'h0004);
    repeat (2) enc.step(1'b0);
    chk16(o_core_count, 16'h0002);
    chk16(16'(irqs), 16'h0006);
    chk1(o_rotation_direction_flag, 1'b1);
    chk1(o_direction_changed_flag, 1'b1);
    chk1(o_count_edge_flag, 1'b1);
    {i_clr_direction_changed, i_clr_count_edge} = 2'h3;
    @(negedge i_clk);
    {i_clr_direction_changed, i_clr_count_edge} = 2'h0;
    @(negedge i_clk);
    chk1(o_direction_changed_flag, 1'b0);
    chk1(o_count_edge_flag, 1'b0);
    $display("test encoder steps done");
    // irq disabled here, so the loop also proves the enable gate
    i_encoder_irq_enable = 1'b0;
    irqs = 0;
    for (int k = 0; k < 3; k++)
    begin
      i_core_edge_select = 3'(k);
      base = int'(o_core_count);
      repeat (4) enc.step(1'b1);
      chk16(o_core_count, 16'(base + sel_gain[k]));
    end
    chk16(16'(irqs), 16'h0000);
    $display("test edge select done");
    {i_core_mode_field, i_core_edge_select, i_encoder_irq_enable, i_core_dir_sw} = {3'h6, 3'h3, 1'b1, 1'b0};
    irqs = 0;
    repeat (2) enc.step(1'b1);
    repeat (2) enc.step(1'b0);
    enc.step(1'b1);
    chk16(16'(irqs), 16'h0002);
    i_core_run_bit = 1'b0;
    base = int'(o_core_count);
    repeat (2) enc.step(1'b1);
    chk16(o_core_count, 16'(base));
    i_core_run_bit = 1'b1;
    $display("test rotation and run done");
    {i_core_mode_field, i_aux_a_edge_select, i_aux_b_edge_select} = {3'h7, 3'h7, 3'h5};
    wr_all(16'hffff, 16'h0010, 16'h0020);
    chk16(o_core_count, 16'hffff);
    enc.step(1'b1);
    chk16(o_core_count, 16'h0000);
    chk1(o_core_overflow_toggle_latch, 1'b1);
    chk16(o_aux_a_count, 16'h0011);
    chk16(o_aux_b_count, 16'h0021);
    enc.step(1'b0);
    chk1(o_core_overflow_toggle_latch, 1'b0);
    chk16(o_aux_a_count, 16'h0012);
    chk16(o_aux_b_count, 16'h0021);
    {i_otl_wr, i_otl_wdata} = 2'h3;
    @(negedge i_clk);
    i_otl_wr = 1'b0;
    enc.hold();
    chk1(o_core_overflow_toggle_latch, 1'b1);
    chk16(o_aux_a_count, 16'h0012);
    $display("test toggle latch done");
    // both count down; aux A follows core run
    {i_aux_b_remote_run, i_aux_b_run_bit, i_aux_b_dir_sw, i_aux_a_run_bit, i_aux_a_remote_run, i_aux_a_dir_sw} = 6'h1b;
    ea = 16'h0012;
    eb = 16'h0021;
    for (int k = 0; k < 3; k++)
    begin
      {i_aux_a_edge_select, i_aux_b_edge_select} = {3'(k + 1), 3'(k + 1)};
      repeat (2) enc.toggle_aux();
      ea -= aux_gain[k];
      eb -= aux_gain[k];
      chk16(o_aux_a_count, 16'(ea));
      chk16(o_aux_b_count, 16'(eb));
    end
    {i_aux_b_remote_run, i_core_run_bit} = 2'h2;
    repeat (2) enc.toggle_aux();
    chk16(o_aux_b_count, 16'(eb));
    chk16(o_aux_a_count, 16'(ea));
    $display("test aux counters done");
    summarize();
  end
endmodule

bind quadrature_timer_block quadrature_timer_block_props chk (.*);
